// [shared/text_pack_pkg.sv]
// Shared constants for the text pack readout and status link
package text_pack_pkg;
  localparam int CLK_MHZ = 125;
  localparam int BUSY_MAX_US = 12;
  localparam int BUSY_MAX_CYC = (BUSY_MAX_US * CLK_MHZ > 0) ? BUSY_MAX_US * CLK_MHZ : 1;
  localparam int BUSY_W = 11;
  localparam logic [4:0] ADDR_MAX_PACKED = 5'h11;
  localparam logic [4:0] ADDR_MAX_PLAIN = 5'h17;
  localparam logic [4:0] ADDR_CORR = 5'h18;
  localparam int CORR_P_LSB = 0;
  localparam int CORR_Q_LSB = 2;
  localparam int CORR_CRC_BIT = 4;
  localparam logic [7:0] RUN_STOP_LIMIT = 8'hBC;
  localparam int SYNC_SAMPLE_DIV = 16;
  localparam int SYNC_MISS_LIMIT = 8;
  localparam int PARAM_BITS = 8;
  localparam int RAM_UNITS = 24;
  localparam logic [1:0] MODE_AUTO = 2'h0;
  localparam logic [1:0] MODE_LEADIN = 2'h1;
  localparam logic [1:0] MODE_NO_DEIL = 2'h2;
  localparam logic [1:0] MODE_DEIL = 2'h3;
endpackage

// [shared/text_pack_if.sv]
// Serial control link between the controller and the disc text readout end
`timescale 1ns/1ns
interface text_pack_if;
  logic cmd_strobe;
  logic [7:0] cmd_word;
  logic [7:0] serial_data_out;
  logic data_valid;
  logic command_busy_flag;
  logic run_length_stop_flag;
  logic sync_lock_flag;
  logic inner_limit_flag;
  modport device (input cmd_strobe, input cmd_word, output serial_data_out, output data_valid,
    output command_busy_flag, output run_length_stop_flag, output sync_lock_flag,
    output inner_limit_flag);
  modport ctrl (output cmd_strobe, output cmd_word, input serial_data_out, input data_valid,
    input command_busy_flag, input run_length_stop_flag, input sync_lock_flag,
    input inner_limit_flag);
endinterface

// [rtl/text_pack_device.sv]
// Disc text pack readout, correction word and status flags, device end
`timescale 1ns/1ns
module text_pack_device
  import text_pack_pkg::*;
#(
  parameter int UNITS = RAM_UNITS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Controller link
  text_pack_if.device link,
  // Pack store, six-bit units written by the demodulator
  input wire logic unit_we,
  input wire logic [4:0] unit_addr,
  input wire logic [5:0] unit_data,
  input wire logic [2:0] item_field,
  input wire logic [1:0] corr_p,
  input wire logic [1:0] corr_q,
  input wire logic crc_ok,
  // Demodulator status inputs
  input wire logic read_frame_tick,
  input wire logic [7:0] inversion_len,
  input wire logic write_frame_tick,
  input wire logic frame_match,
  input wire logic limit_switch,
  input wire logic adaptive_clv,
  // Decode controls to the correction engine
  output logic deinterleave,
  output logic correct_en,
  output logic leadin_servo
);
  typedef enum logic [1:0] {ST_IDLE, ST_PARAM, ST_READ} rd_state_t;

  rd_state_t state_r;
  logic [5:0] ram_r [UNITS];
  logic [1:0] mode_r;
  logic pack_r;
  logic [4:0] addr_r;
  logic [7:0] dout_r;
  logic valid_r;
  logic [BUSY_W-1:0] busy_cnt_r;
  logic [7:0] peak_r;
  logic stop_r;
  logic [3:0] wdiv_r;
  logic [3:0] miss_r;
  logic lock_r;
  logic limit_r;
  logic [7:0] word_nxt;
  logic [5:0] u0, u1;
  logic [4:0] base;
  logic [1:0] phase;

  // Pack store, one flip-flop row per six-bit unit
  always_ff @(posedge clk) begin
    if (unit_we && unit_addr < 5'(UNITS)) begin
      ram_r[unit_addr] <= unit_data;
    end
  end

  // Packed byte k of group g spans units 4g+k and 4g+k+1; a group of three covers units 4g..4g+3
  always_comb begin
    base = 5'((addr_r / 5'd3) * 5'd4);
    phase = 2'(addr_r % 5'd3);
    u0 = 6'h00;
    u1 = 6'h00;
    word_nxt = 8'h00;
    if (addr_r == ADDR_CORR) begin
      word_nxt[CORR_P_LSB +: 2] = corr_p;
      word_nxt[CORR_Q_LSB +: 2] = corr_q;
      word_nxt[CORR_CRC_BIT] = crc_ok;
    end else if (!pack_r) begin
      if (addr_r < 5'(UNITS)) begin
        word_nxt = {2'b00, ram_r[addr_r]};
      end
    end else begin
      // Base arithmetic can wrap above the packed range, so such addresses are gated off by the ADDR_MAX_PACKED check and read zero
      if (addr_r <= ADDR_MAX_PACKED && 5'(base + 5'(phase) + 5'd1) < 5'(UNITS)) begin
        u0 = ram_r[base + 5'(phase)];
        u1 = ram_r[base + 5'(phase) + 5'd1];
      end
      case (phase)
        2'd0: word_nxt = {u0, u1[5:4]};
        2'd1: word_nxt = {u0[3:0], u1[5:2]};
        2'd2: word_nxt = {u0[1:0], u1};
        default: word_nxt = 8'h00;
      endcase
    end
  end

  // One parameter byte {mode, packing select, addr}, no command word ahead of it
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      mode_r <= MODE_AUTO;
      pack_r <= 1'b1;
      addr_r <= 5'h00;
      dout_r <= 8'h00;
      valid_r <= 1'b0;
      busy_cnt_r <= '0;
    end else begin
      valid_r <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (link.cmd_strobe) begin
            mode_r <= link.cmd_word[7:6];
            pack_r <= ~link.cmd_word[5];
            addr_r <= link.cmd_word[4:0];
            busy_cnt_r <= BUSY_W'(BUSY_MAX_CYC - 1);
            state_r <= ST_PARAM;
          end
        end
        ST_PARAM: state_r <= ST_READ;
        ST_READ: begin
          dout_r <= word_nxt;
          valid_r <= 1'b1;
          busy_cnt_r <= '0;
          state_r <= ST_IDLE;
        end
        default: state_r <= ST_IDLE;
      endcase
      if (state_r != ST_IDLE && busy_cnt_r != '0 && state_r != ST_READ) begin
        busy_cnt_r <= busy_cnt_r - BUSY_W'(1);
      end
    end
  end

  // Interleave and correction controls from the decode mode
  always_comb begin
    correct_en = 1'b1;
    case (mode_r)
      MODE_AUTO: deinterleave = item_field != 3'b000;
      MODE_LEADIN: begin
        deinterleave = 1'b0;
        correct_en = 1'b0;
      end
      MODE_NO_DEIL: deinterleave = 1'b0;
      MODE_DEIL: deinterleave = 1'b1;
      default: deinterleave = 1'b0;
    endcase
  end

  // Peak hold of inversion length across each read frame
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      peak_r <= 8'h00;
      stop_r <= 1'b0;
    end else if (read_frame_tick) begin
      stop_r <= (inversion_len > peak_r ? inversion_len : peak_r) >= RUN_STOP_LIMIT;
      peak_r <= 8'h00;
    end else if (inversion_len > peak_r) begin
      peak_r <= inversion_len;
    end
  end

  // Sync lock: sampled every sixteenth write frame
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wdiv_r <= 4'h0;
      miss_r <= 4'h0;
      lock_r <= 1'b1;
    end else if (write_frame_tick) begin
      wdiv_r <= wdiv_r + 4'h1;
      if (wdiv_r == 4'(SYNC_SAMPLE_DIV - 1)) begin
        if (frame_match) begin
          miss_r <= 4'h0;
          lock_r <= 1'b1;
        end else if (miss_r == 4'(SYNC_MISS_LIMIT - 1)) begin
          lock_r <= 1'b0;
        end else begin
          miss_r <= miss_r + 4'h1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      limit_r <= 1'b0;
    end else begin
      limit_r <= limit_switch;
    end
  end

  assign leadin_servo = adaptive_clv & ~lock_r;
  assign link.serial_data_out = dout_r;
  assign link.data_valid = valid_r;
  // The down-counter caps the busy window even if the sequence were ever to stall
  assign link.command_busy_flag = state_r != ST_IDLE && busy_cnt_r != '0;
  assign link.run_length_stop_flag = stop_r;
  assign link.sync_lock_flag = lock_r;
  assign link.inner_limit_flag = limit_r;
endmodule // text_pack_device

// [rtl/text_pack_ctrl.sv]
// Controller end: issues pack readout parameters and reads back bytes
`timescale 1ns/1ns
module text_pack_ctrl
  import text_pack_pkg::*;
#(
  parameter int STOP_READS = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // User request
  input wire logic req,
  input wire logic [1:0] req_mode,
  input wire logic req_item_check,
  input wire logic [4:0] req_addr,
  output logic req_ready,
  output logic [7:0] rd_data,
  output logic rd_valid,
  output logic spindle_stopped,
  // Device link
  text_pack_if.ctrl link
);
  logic [7:0] rd_r;
  logic rdv_r;
  logic [3:0] stop_cnt_r;
  logic sz;
  logic [4:0] lim;
  logic [4:0] addr;

  // Unpacked reads except program-area data without item checks
  assign sz = (req_mode == MODE_LEADIN) || req_item_check;
  assign lim = sz ? ADDR_MAX_PLAIN : ADDR_MAX_PACKED;
  assign addr = (req_addr == ADDR_CORR || req_addr <= lim) ? req_addr : lim;
  assign req_ready = ~link.command_busy_flag;
  assign link.cmd_strobe = req & req_ready;
  assign link.cmd_word = {req_mode, sz, addr};

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_r <= 8'h00;
      rdv_r <= 1'b0;
    end else begin
      rdv_r <= link.data_valid;
      if (link.data_valid) begin
        rd_r <= link.serial_data_out;
      end
    end
  end

  // Stop is believed only after several consecutive flag reads
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      stop_cnt_r <= 4'h0;
    end else if (!link.run_length_stop_flag) begin
      stop_cnt_r <= 4'h0;
    end else if (stop_cnt_r != 4'(STOP_READS)) begin
      stop_cnt_r <= stop_cnt_r + 4'h1;
    end
  end

  assign rd_data = rd_r;
  assign rd_valid = rdv_r;
  assign spindle_stopped = stop_cnt_r == 4'(STOP_READS);
endmodule // text_pack_ctrl

// [bench/text_pack_props.sv]
// Timing and content checks on the controller link
`timescale 1ns/1ns
module text_pack_props
  import text_pack_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Link signals
  input wire logic cmd_strobe,
  input wire logic [7:0] cmd_word,
  input wire logic [7:0] serial_data_out,
  input wire logic data_valid,
  input wire logic command_busy_flag,
  input wire logic run_length_stop_flag,
  input wire logic sync_lock_flag,
  input wire logic inner_limit_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic take;
  logic [7:0] word_r;
  assign take = cmd_strobe & ~command_busy_flag;
  // Busy windows never overlap, so the last word taken owns the next reply
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      word_r <= 8'h00;
    end else if (take) begin
      word_r <= cmd_word;
    end
  end
  a_busy_after_take: assert property (take |=> command_busy_flag[*2] ##1 !command_busy_flag)
    else $error("busy window wrong");
  a_reply_on_time: assert property (take |-> ##3 data_valid)
    else $error("reply late");
  a_reply_has_cause: assert property (data_valid |-> $past(take, 3))
    else $error("reply without request");
  a_reply_one_cycle: assert property (data_valid |=> !data_valid)
    else $error("valid too long");
  a_data_held: assert property (!data_valid |-> $stable(serial_data_out))
    else $error("data moved between replies");
  a_corr_unpacked: assert property (data_valid && word_r[4:0] == ADDR_CORR |->
    serial_data_out[7:5] == 3'h0) else $error("result word packed");
  a_plain_right: assert property (data_valid && word_r[5] && word_r[4:0] <= ADDR_MAX_PLAIN |->
    serial_data_out[7:6] == 2'h0) else $error("unit not right-justified");
  a_addr_clamped: assert property (take && cmd_word[4:0] != ADDR_CORR |->
    cmd_word[4:0] <= (cmd_word[5] ? ADDR_MAX_PLAIN : ADDR_MAX_PACKED))
    else $error("address out of range");
  c_corr_read: cover property (take && cmd_word[4:0] == ADDR_CORR);
  c_lock_lost: cover property ($fell(sync_lock_flag));
  c_stop_seen: cover property ($rose(run_length_stop_flag));
  c_limit_set: cover property ($rose(inner_limit_flag));
endmodule // text_pack_props

// [bench/tb_disc_text_pack_readout_status.sv]
// Self-checking bench joining controller end and device end
`timescale 1ns/1ns
module tb_disc_text_pack_readout_status;
  import text_pack_pkg::*;
  logic clk = 0, sys_rst = 1, unit_we = 0, crc_ok = 0, read_frame_tick = 0;
  logic write_frame_tick = 0, frame_match = 0, limit_switch = 0, adaptive_clv = 0;
  logic req = 0, req_item_check = 0, req_ready, rd_valid, spindle_stopped;
  logic deinterleave, correct_en, leadin_servo;
  logic [1:0] corr_p = 0, corr_q = 0, req_mode = 0;
  logic [2:0] item_field = 0;
  logic [4:0] unit_addr = 0, req_addr = 0;
  logic [5:0] unit_data = 0;
  logic [7:0] inversion_len = 0, rd_data;
  logic [5:0] mem [RAM_UNITS];
  int fails = 0, compares = 0;
  text_pack_if l ();
  text_pack_device i_text_pack_device (.clk, .sys_rst, .link(l.device), .unit_we, .unit_addr,
    .unit_data, .item_field, .corr_p, .corr_q, .crc_ok, .read_frame_tick, .inversion_len,
    .write_frame_tick, .frame_match, .limit_switch, .adaptive_clv, .deinterleave, .correct_en,
    .leadin_servo);
  text_pack_ctrl i_text_pack_ctrl (.clk, .sys_rst, .req, .req_mode, .req_item_check, .req_addr,
    .req_ready, .rd_data, .rd_valid, .spindle_stopped, .link(l.ctrl));
  text_pack_props i_text_pack_props (.clk, .sys_rst, .cmd_strobe(l.cmd_strobe),
    .cmd_word(l.cmd_word), .serial_data_out(l.serial_data_out), .data_valid(l.data_valid),
    .command_busy_flag(l.command_busy_flag), .run_length_stop_flag(l.run_length_stop_flag),
    .sync_lock_flag(l.sync_lock_flag), .inner_limit_flag(l.inner_limit_flag));
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    if (fails == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  function automatic logic [7:0] model(input logic [1:0] m, input logic ic, input logic [4:0] a);
    int p;
    logic [5:0] ua, ub;
    logic [4:0] lim;
    lim = (m == MODE_LEADIN || ic) ? ADDR_MAX_PLAIN : ADDR_MAX_PACKED;
    if (a != ADDR_CORR && a > lim) a = lim;
    p = a % 3;
    // Index wraps only for addresses that never take the packed path
    ua = mem[(4 * (a / 3) + p) % RAM_UNITS];
    ub = mem[(4 * (a / 3) + p + 1) % RAM_UNITS];
    if (a == ADDR_CORR) return {3'h0, crc_ok, corr_q, corr_p};
    if (m == MODE_LEADIN || ic) return {2'h0, mem[a]};
    case (p)
      0: return {ua, ub[5:4]};
      1: return {ua[3:0], ub[5:2]};
      default: return {ua[1:0], ub};
    endcase
  endfunction
  task automatic rd(input logic [1:0] m, input logic ic, input logic [4:0] a);
    int n;
    n = 0;
    while (req_ready !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    if (n >= 50) fails++;
    req_mode = m;
    req_item_check = ic;
    req_addr = a;
    req = 1;
    @(negedge clk);
    req = 0;
    n = 0;
    while (rd_valid !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (n >= 20) fails++;
    chk(rd_data, model(m, ic, a));
    chk({6'h0, deinterleave, correct_en}, {6'h0, m == MODE_DEIL ||
      (m == MODE_AUTO && item_field != 3'h0), m != MODE_LEADIN});
  endtask
  initial begin
    forever #4 clk = ~clk;
  end
  initial begin
    #160000;
    fails++;
    test_done();
  end
  initial begin
    logic [1:0] m;
    logic ic;
    logic [4:0] a;
    void'($urandom(64));
    repeat (8) @(negedge clk);
    sys_rst = 0;
    adaptive_clv = 1;
    for (int i = 1; i <= 144; i++) begin
      frame_match = i > 128;
      write_frame_tick = 1;
      @(negedge clk);
      write_frame_tick = 0;
      @(negedge clk);
      if (i >= 127) begin
        chk({7'h0, l.sync_lock_flag}, {7'h0, i < 128 || i == 144});
        chk({7'h0, leadin_servo}, {7'h0, i >= 128 && i < 144});
      end
    end
    for (int k = 0; k < 4; k++) begin
      inversion_len = RUN_STOP_LIMIT - 8'(k[0]);
      limit_switch = k[1];
      repeat (3) @(negedge clk);
      // Previous frame's flag has stood four cycles, past the three-read threshold
      chk({7'h0, spindle_stopped}, {7'h0, k[0]});
      read_frame_tick = 1;
      @(negedge clk);
      read_frame_tick = 0;
      // Quiet line after the tick, so this frame's peak does not leak into the next
      inversion_len = 8'h00;
      @(negedge clk);
      chk({7'h0, l.run_length_stop_flag}, {7'h0, !k[0]});
      chk({7'h0, l.inner_limit_flag}, {7'h0, k[1]});
    end
    for (int i = 0; i < RAM_UNITS; i++) begin
      unit_we = 1;
      unit_addr = i[4:0];
      unit_data = 6'($urandom);
      mem[i] = unit_data;
      @(negedge clk);
    end
    unit_we = 0;
    for (int i = 0; i < 80; i++) begin
      m = 2'($urandom);
      ic = 1'($urandom);
      item_field = 3'($urandom);
      {crc_ok, corr_q, corr_p} = 5'($urandom);
      adaptive_clv = 1'($urandom);
      a = 5'($urandom);
      if (i % 8 == 0) a = ADDR_CORR;
      rd(m, ic, a);
    end
    test_done();
  end
endmodule // tb_disc_text_pack_readout_status
